//--- core/sdcps_consts.vh
// Constants for the synchronous DRAM command sequencer on the controller side.
// Assumes inclusion by bare name from every design file of the block.
`ifndef SDCPS_CONSTS_VH
`define SDCPS_CONSTS_VH
// Strobe codes {ras_n, cas_n, we_n} with chip select low.
`define SDCPS_CODE_MODESET    3'h0
`define SDCPS_CODE_REFRESH    3'h1
`define SDCPS_CODE_PRECHARGE  3'h2
`define SDCPS_CODE_ACTIVATE   3'h3
`define SDCPS_CODE_WRITE      3'h4
`define SDCPS_CODE_READ       3'h5
`define SDCPS_CODE_CALIB      3'h6
`define SDCPS_CODE_NOP        3'h7
// Request opcodes on the user port.
`define SDCPS_OP_MODESET      4'h0
`define SDCPS_OP_REFRESH      4'h1
`define SDCPS_OP_PRECHARGE    4'h2
`define SDCPS_OP_ACTIVATE     4'h3
`define SDCPS_OP_WRITE        4'h4
`define SDCPS_OP_READ         4'h5
`define SDCPS_OP_CALIB        4'h6
`define SDCPS_OP_PD_ENTER     4'h8
`define SDCPS_OP_PD_EXIT      4'h9
`define SDCPS_OP_SR_ENTER     4'hA
`define SDCPS_OP_SR_EXIT      4'hB
// Address bit positions.
`define SDCPS_AUTOCLOSE_BIT   10
`define SDCPS_CHOP_BIT        12
// Delay defaults in clock cycles.
`define SDCPS_MODESET_TO_CMD  4
`define SDCPS_MODESET_TO_OTH  12
`define SDCPS_MIN_PULSE       3
`define SDCPS_SLEEP_EXIT      100
`define SDCPS_SLEEP_EXIT_LOCK 512
`define SDCPS_PD_EXIT         3
`define SDCPS_WRITE_AFTER_SR  512
`define SDCPS_BURST8          4
`define SDCPS_BURST4          2
`define SDCPS_CLOSE_DELAY     6
`endif

//--- core/sdcps_delay.v
// Down counter giving a done level once a loaded cycle count has run out.
// Assumes loads come from logic on the same clock.
`timescale 1ns/1ps
`include "sdcps_consts.vh"
module sdcps_delay #(
  parameter W = 10
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_n_i,
  // Load and status
  input  wire         load_i,
  input  wire [W-1:0] count_i,
  output wire         done_o
);
  reg [W-1:0] cnt_r;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= {W{1'b0}};
    end else if (load_i) begin
      cnt_r <= count_i;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign done_o = (cnt_r == {W{1'b0}});
endmodule // sdcps_delay

//--- core/sdcps_ctrl.v
// Controller that drives a synchronous DRAM command and power-state pins.
// Assumes user requests come from logic on CLK_I; the memory samples pins on the rising edge.
`timescale 1ns/1ps
`include "sdcps_consts.vh"
module sdcps_ctrl #(
  parameter AW          = 14,
  parameter BW          = 3,
  parameter NB          = 8,
  parameter T_MRD       = `SDCPS_MODESET_TO_CMD,
  parameter T_MOD       = `SDCPS_MODESET_TO_OTH,
  parameter T_CKE       = `SDCPS_MIN_PULSE,
  parameter T_XS        = `SDCPS_SLEEP_EXIT,
  parameter T_XSDLL     = `SDCPS_SLEEP_EXIT_LOCK,
  parameter T_XP        = `SDCPS_PD_EXIT,
  parameter T_WRSR      = `SDCPS_WRITE_AFTER_SR,
  parameter T_BL8       = `SDCPS_BURST8,
  parameter T_BC4       = `SDCPS_BURST4,
  parameter T_CLOSE     = `SDCPS_CLOSE_DELAY
) (
  // Clock and reset
  input  wire          CLK_I,
  input  wire          RST_N_I,
  // User request port
  input  wire          REQ_VALID_I,
  input  wire [3:0]    REQ_OP_I,
  input  wire [BW-1:0] REQ_BANK_I,
  input  wire [AW-1:0] REQ_ADDR_I,
  input  wire          REQ_TERM_I,
  output reg           REQ_READY_O,
  output reg           REQ_ACCEPT_O,
  output reg           REQ_REFUSE_O,
  // Status
  output reg  [2:0]    STATE_O,
  output reg           IDLE_O,
  // Memory pins
  output reg           MEM_RESET_N_O,
  output reg           MEM_CKE_O,
  output reg           MEM_CS_N_O,
  output reg           MEM_RAS_N_O,
  output reg           MEM_CAS_N_O,
  output reg           MEM_WE_N_O,
  output reg  [BW-1:0] MEM_BA_O,
  output reg  [AW-1:0] MEM_ADDR_O,
  output reg           MEM_TERM_O
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ACT  = 3'h1;
  localparam ST_APD  = 3'h2;
  localparam ST_PPD  = 3'h3;
  localparam ST_SR   = 3'h4;
  localparam ST_PDW  = 3'h5;

  reg [2:0]    state_r;
  reg [NB-1:0] open_r;
  wire d_burst, d_mrd, d_mod, d_cke, d_xs, d_xsdll, d_xp, d_wrsr, d_close;
  reg  l_burst, l_mrd, l_mod, l_cke, l_xs, l_xsdll, l_xp, l_wrsr, l_close;
  reg  [9:0] burst_cnt;

  sdcps_delay #(.W(10)) u_burst (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(l_burst), .count_i(burst_cnt), .done_o(d_burst));
  sdcps_delay #(.W(10)) u_mrd (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(l_mrd), .count_i(T_MRD[9:0]), .done_o(d_mrd));
  sdcps_delay #(.W(10)) u_mod (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(l_mod), .count_i(T_MOD[9:0]), .done_o(d_mod));
  sdcps_delay #(.W(10)) u_cke (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(l_cke), .count_i(T_CKE[9:0]), .done_o(d_cke));
  sdcps_delay #(.W(10)) u_xs (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(l_xs), .count_i(T_XS[9:0]), .done_o(d_xs));
  sdcps_delay #(.W(10)) u_xsdll (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(l_xsdll), .count_i(T_XSDLL[9:0]),
                                 .done_o(d_xsdll));
  sdcps_delay #(.W(10)) u_xp (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(l_xp), .count_i(T_XP[9:0]), .done_o(d_xp));
  sdcps_delay #(.W(10)) u_wrsr (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(l_wrsr), .count_i(T_WRSR[9:0]),
                                .done_o(d_wrsr));
  sdcps_delay #(.W(10)) u_close (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(l_close), .count_i(T_CLOSE[9:0]),
                                 .done_o(d_close));

  wire all_closed = (open_r == {NB{1'b0}});
  wire timers_ok  = d_burst & d_mrd & d_mod & d_xs & d_xp & d_close;
  wire bank_open  = open_r[REQ_BANK_I];
  wire is_pd      = (state_r == ST_APD) | (state_r == ST_PPD) | (state_r == ST_SR);

  reg          ok;
  reg [2:0]    code;
  reg [2:0]    state_nxt;
  reg [NB-1:0] open_nxt;
  reg          cke_nxt;

  always @* begin
    ok = 1'b0;
    code = `SDCPS_CODE_NOP;
    state_nxt = state_r;
    open_nxt = open_r;
    cke_nxt = MEM_CKE_O;
    l_burst = 1'b0; l_mrd = 1'b0; l_mod = 1'b0; l_cke = 1'b0; l_xs = 1'b0;
    l_xsdll = 1'b0; l_xp = 1'b0; l_wrsr = 1'b0; l_close = 1'b0;
    burst_cnt = REQ_ADDR_I[`SDCPS_CHOP_BIT] ? T_BL8[9:0] : T_BC4[9:0];
    if (state_r == ST_PDW) begin
      if (d_burst & d_close & d_cke) begin
        cke_nxt = 1'b0;
        l_cke = 1'b1;
        state_nxt = all_closed ? ST_PPD : ST_APD;
      end
    end else if (REQ_VALID_I) begin
      case (REQ_OP_I)
        `SDCPS_OP_MODESET: begin
          ok = (state_r == ST_IDLE) & all_closed & timers_ok;
          code = `SDCPS_CODE_MODESET;
          l_mrd = ok; l_mod = ok;
        end
        `SDCPS_OP_REFRESH: begin
          ok = (state_r == ST_IDLE) & all_closed & timers_ok;
          code = `SDCPS_CODE_REFRESH;
          l_close = ok;
        end
        `SDCPS_OP_PRECHARGE: begin
          ok = ~is_pd & d_burst & d_mrd;
          code = `SDCPS_CODE_PRECHARGE;
          l_close = ok;
          if (ok) begin
            if (REQ_ADDR_I[`SDCPS_AUTOCLOSE_BIT]) open_nxt = {NB{1'b0}};
            else open_nxt[REQ_BANK_I] = 1'b0;
          end
        end
        `SDCPS_OP_ACTIVATE: begin
          ok = ~is_pd & ~bank_open & timers_ok;
          code = `SDCPS_CODE_ACTIVATE;
          if (ok) open_nxt[REQ_BANK_I] = 1'b1;
        end
        `SDCPS_OP_WRITE, `SDCPS_OP_READ: begin
          ok = ~is_pd & bank_open & d_burst & d_mrd & d_xp
               & ((REQ_OP_I == `SDCPS_OP_WRITE) ? d_wrsr : d_xsdll);
          code = (REQ_OP_I == `SDCPS_OP_WRITE) ? `SDCPS_CODE_WRITE : `SDCPS_CODE_READ;
          l_burst = ok;
          if (ok & REQ_ADDR_I[`SDCPS_AUTOCLOSE_BIT]) begin
            open_nxt[REQ_BANK_I] = 1'b0;
            l_close = 1'b1;
          end
        end
        `SDCPS_OP_CALIB: begin
          ok = (state_r == ST_IDLE) & all_closed & timers_ok;
          code = `SDCPS_CODE_CALIB;
          l_close = ok;
        end
        `SDCPS_OP_PD_ENTER: begin
          ok = ((state_r == ST_IDLE) | (state_r == ST_ACT)) & d_mrd & d_mod & d_cke;
          if (ok) state_nxt = ST_PDW;
        end
        `SDCPS_OP_SR_ENTER: begin
          ok = (state_r == ST_IDLE) & all_closed & timers_ok & d_cke;
          code = `SDCPS_CODE_REFRESH;
          if (ok) begin
            cke_nxt = 1'b0;
            l_cke = 1'b1;
            state_nxt = ST_SR;
          end
        end
        `SDCPS_OP_PD_EXIT, `SDCPS_OP_SR_EXIT: begin
          ok = d_cke & (((REQ_OP_I == `SDCPS_OP_SR_EXIT) & (state_r == ST_SR)) |
                        ((REQ_OP_I == `SDCPS_OP_PD_EXIT) & ((state_r == ST_APD) | (state_r == ST_PPD))));
          if (ok) begin
            cke_nxt = 1'b1;
            l_cke = 1'b1;
            l_xp = (REQ_OP_I == `SDCPS_OP_PD_EXIT);
            l_xs = (REQ_OP_I == `SDCPS_OP_SR_EXIT);
            l_xsdll = l_xs;
            l_wrsr = l_xs;
            state_nxt = (state_r == ST_APD) ? ST_ACT : ST_IDLE;
          end
        end
        default: ok = 1'b0;
      endcase
      if (!ok) code = `SDCPS_CODE_NOP;
    end
    if ((state_nxt == ST_IDLE) | (state_nxt == ST_ACT)) begin
      state_nxt = (open_nxt == {NB{1'b0}}) ? ST_IDLE : ST_ACT;
    end
  end

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r       <= ST_IDLE;
      open_r        <= {NB{1'b0}};
      REQ_READY_O   <= 1'b0;
      REQ_ACCEPT_O  <= 1'b0;
      REQ_REFUSE_O  <= 1'b0;
      STATE_O       <= ST_IDLE;
      IDLE_O        <= 1'b0;
      MEM_RESET_N_O <= 1'b0;
      MEM_CKE_O     <= 1'b1;
      MEM_CS_N_O    <= 1'b1;
      MEM_RAS_N_O   <= 1'b1;
      MEM_CAS_N_O   <= 1'b1;
      MEM_WE_N_O    <= 1'b1;
      MEM_BA_O      <= {BW{1'b0}};
      MEM_ADDR_O    <= {AW{1'b0}};
      MEM_TERM_O    <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      open_r        <= open_nxt;
      REQ_READY_O   <= (state_nxt != ST_PDW);
      REQ_ACCEPT_O  <= REQ_VALID_I & ok;
      REQ_REFUSE_O  <= REQ_VALID_I & ~ok & (state_r != ST_PDW);
      STATE_O       <= state_nxt;
      IDLE_O        <= (state_nxt == ST_IDLE) & cke_nxt & timers_ok
                       & ~(l_burst | l_mrd | l_mod | l_xs | l_xp | l_close);
      MEM_RESET_N_O <= 1'b1;
      MEM_CKE_O     <= cke_nxt;
      MEM_CS_N_O    <= (code == `SDCPS_CODE_NOP);
      {MEM_RAS_N_O, MEM_CAS_N_O, MEM_WE_N_O} <= code;
      MEM_BA_O      <= (code == `SDCPS_CODE_NOP) ? {BW{1'b0}} : REQ_BANK_I;
      MEM_ADDR_O    <= (code == `SDCPS_CODE_NOP) ? {AW{1'b0}} : REQ_ADDR_I;
      MEM_TERM_O    <= REQ_TERM_I & (state_nxt != ST_SR) & d_xsdll & ~l_xsdll;
    end
  end
endmodule // sdcps_ctrl

//--- test/sdcps_ctrl_chk.sv
// Checker of the command pins and handshake of the DRAM command controller.
// Assumes a bind to sdcps_ctrl and sees only its ports.
`timescale 1ns/1ps
`include "sdcps_consts.vh"
module sdcps_ctrl_chk (
  // Clock and reset
  input wire logic       CLK_I,
  input wire logic       RST_N_I,
  // Observed outputs
  input wire logic       REQ_ACCEPT_O,
  input wire logic       REQ_REFUSE_O,
  input wire logic [2:0] STATE_O,
  input wire logic       IDLE_O,
  input wire logic       MEM_RESET_N_O,
  input wire logic       MEM_CKE_O,
  input wire logic       MEM_CS_N_O,
  input wire logic       MEM_RAS_N_O,
  input wire logic       MEM_CAS_N_O,
  input wire logic       MEM_WE_N_O,
  input wire logic       MEM_TERM_O
);
  wire [2:0] code = {MEM_RAS_N_O, MEM_CAS_N_O, MEM_WE_N_O};
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_reset_pin_high: assert property ($past(RST_N_I) |-> MEM_RESET_N_O) else $error("reset pin low");
  a_cmd_only_accept: assert property (!REQ_ACCEPT_O |-> MEM_CS_N_O) else $error("stray command");
  a_refuse_no_cmd: assert property (REQ_REFUSE_O |-> !REQ_ACCEPT_O && MEM_CS_N_O) else $error("refused sent");
  a_sleep_entry_code: assert property ($fell(MEM_CKE_O) && !MEM_CS_N_O |->
    code == `SDCPS_CODE_REFRESH && STATE_O == 3'h4) else $error("bad sleep entry");
  a_wake_edge_idle: assert property ($rose(MEM_CKE_O) |-> MEM_CS_N_O || code == `SDCPS_CODE_NOP)
    else $error("command on wake edge");
  a_pd_entry_idle: assert property ($fell(MEM_CKE_O) && STATE_O inside {3'h2, 3'h3} |-> MEM_CS_N_O)
    else $error("command on power down entry");
  a_enable_hold: assert property ($changed(MEM_CKE_O) |=> $stable(MEM_CKE_O) [*2]) else $error("short pulse");
  a_low_enable_quiet: assert property (!MEM_CKE_O && !$past(MEM_CKE_O) |-> MEM_CS_N_O)
    else $error("command in power down");
  a_term_sleep_low: assert property (STATE_O == 3'h4 |-> !MEM_TERM_O) else $error("term in sleep");
  a_idle_enable_high: assert property (IDLE_O |-> MEM_CKE_O) else $error("idle with enable low");
  a_pd_enable_low: assert property (STATE_O inside {3'h2, 3'h3} |-> !MEM_CKE_O) else $error("pd enable high");
endmodule // sdcps_ctrl_chk
bind sdcps_ctrl sdcps_ctrl_chk i_sdcps_ctrl_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REQ_ACCEPT_O(REQ_ACCEPT_O),
  .REQ_REFUSE_O(REQ_REFUSE_O), .STATE_O(STATE_O), .IDLE_O(IDLE_O), .MEM_RESET_N_O(MEM_RESET_N_O),
  .MEM_CKE_O(MEM_CKE_O), .MEM_CS_N_O(MEM_CS_N_O), .MEM_RAS_N_O(MEM_RAS_N_O), .MEM_CAS_N_O(MEM_CAS_N_O),
  .MEM_WE_N_O(MEM_WE_N_O), .MEM_TERM_O(MEM_TERM_O));

//--- test/sdcps_dev.sv
// Model of the memory command decode and power states; counts illegal sequences.
// Assumes pins change just after the rising edge of clk_i.
`timescale 1ns/1ps
`include "sdcps_consts.vh"
module sdcps_dev #(
  parameter T_SX = 512
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        cke_i,
  input  wire        cs_n_i,
  input  wire [2:0]  cmd_n_i,
  input  wire [2:0]  ba_i,
  input  wire [13:0] addr_i,
  input  wire        term_i,
  output int         err_o
);
  logic       cke_q;
  logic       sr;
  logic [7:0] open_b;
  int         since_sx;
  // Power down keeps no refresh timer at all.
  wire cmd = cke_i && cke_q && !cs_n_i;
  wire sleep_refresh_entry = cke_q && !cke_i && !cs_n_i && cmd_n_i == `SDCPS_CODE_REFRESH;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cke_q    <= 1'b1;
      sr       <= 1'b0;
      open_b   <= 8'h00;
      since_sx <= T_SX;
      err_o    <= 0;
    end else begin
      cke_q    <= cke_i;
      since_sx <= (since_sx < T_SX) ? since_sx + 1 : since_sx;
      if (cke_i != cke_q && !cs_n_i && !sleep_refresh_entry && cmd_n_i != `SDCPS_CODE_NOP) err_o <= err_o + 1;
      if (sleep_refresh_entry && open_b != 8'h00) err_o <= err_o + 1;
      if (sleep_refresh_entry) sr <= 1'b1;
      if (sr && term_i) err_o <= err_o + 1;
      if (sr && !cke_q && cke_i) begin
        sr       <= 1'b0;
        since_sx <= 1;
      end
      if (cmd) case (cmd_n_i)
        `SDCPS_CODE_ACTIVATE: begin
          if (open_b[ba_i]) err_o <= err_o + 1;
          open_b[ba_i] <= 1'b1;
        end
        `SDCPS_CODE_READ, `SDCPS_CODE_WRITE: begin
          if (!open_b[ba_i] || since_sx < T_SX) err_o <= err_o + 1;
          if (addr_i[10]) open_b[ba_i] <= 1'b0;
        end
        `SDCPS_CODE_PRECHARGE: begin
          if (addr_i[10]) open_b <= 8'h00;
          else open_b[ba_i] <= 1'b0;
        end
        `SDCPS_CODE_MODESET, `SDCPS_CODE_REFRESH: if (open_b != 8'h00) err_o <= err_o + 1;
        default: ;
      endcase
    end
  end
endmodule // sdcps_dev

//--- test/sdcps_ctrl_test.sv
// Self-checking bench of the DRAM command controller against a memory model.
// Assumes the design, checker and model files are compiled first.
`timescale 1ns/1ps
module sdcps_ctrl_test;
  logic        CLK_I, RST_N_I, REQ_VALID_I, REQ_TERM_I;
  logic [3:0]  REQ_OP_I;
  logic [2:0]  REQ_BANK_I;
  logic [13:0] REQ_ADDR_I;
  wire         rdy, ack, nak, idle, rst_n, cke, cs_n, ras_n, cas_n, we_n, term;
  wire  [2:0]  st, ba;
  wire  [13:0] addr;
  int          num_errors = 0, tests_run = 0, cyc = 0, dev_err;
  sdcps_ctrl i_sdcps_ctrl (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REQ_VALID_I(REQ_VALID_I),
    .REQ_OP_I(REQ_OP_I), .REQ_BANK_I(REQ_BANK_I), .REQ_ADDR_I(REQ_ADDR_I), .REQ_TERM_I(REQ_TERM_I),
    .REQ_READY_O(rdy), .REQ_ACCEPT_O(ack), .REQ_REFUSE_O(nak), .STATE_O(st), .IDLE_O(idle),
    .MEM_RESET_N_O(rst_n), .MEM_CKE_O(cke), .MEM_CS_N_O(cs_n), .MEM_RAS_N_O(ras_n), .MEM_CAS_N_O(cas_n),
    .MEM_WE_N_O(we_n), .MEM_BA_O(ba), .MEM_ADDR_O(addr), .MEM_TERM_O(term));
  sdcps_dev i_sdcps_dev (.clk_i(CLK_I), .rst_n_i(rst_n), .cke_i(cke), .cs_n_i(cs_n),
    .cmd_n_i({ras_n, cas_n, we_n}), .ba_i(ba), .addr_i(addr), .term_i(term), .err_o(dev_err));
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic req(input logic [3:0] op, input logic [2:0] b, input logic [13:0] a, input logic ok);
    @(posedge CLK_I);
    REQ_VALID_I <= 1'b1;
    REQ_OP_I    <= op;
    REQ_BANK_I  <= b;
    REQ_ADDR_I  <= a;
    @(posedge CLK_I);
    REQ_VALID_I <= 1'b0;
    #1;
    chk({ack, nak}, {ok, !ok});
  endtask
  task automatic cmd(input logic [2:0] c);
    chk({cs_n, ras_n, cas_n, we_n}, {1'b0, c});
  endtask
  task automatic wait_st(input logic [2:0] s);
    for (int n = 0; n < 40 && st !== s; n++) @(posedge CLK_I) #1;
    chk(st, s);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge CLK_I);
  endtask
  task t_codes;
    gap(4);
    req(4'h1, 3'h0, 14'h0000, 1'b1);
    cmd(3'h1);
    gap(8);
    req(4'h6, 3'h0, 14'h0400, 1'b1);
    chk({addr[10], ras_n, cas_n, we_n}, 4'hE);
  endtask
  task t_pd;
    gap(8);
    req(4'h0, 3'h2, 14'h0000, 1'b1);
    chk({cs_n, ras_n, cas_n, we_n, 1'b0, ba}, 8'h02);
    req(4'h8, 3'h0, 14'h0000, 1'b0);
    gap(16);
    req(4'h8, 3'h0, 14'h0000, 1'b1);
    chk(rdy, 1'b0);
    wait_st(3'h3);
    chk(rdy, 1'b1);
    req(4'h4, 3'h0, 14'h0000, 1'b0);
    chk(cke, 1'b0);
    req(4'h9, 3'h0, 14'h0000, 1'b1);
    chk({cke, cs_n}, 2'h3);
  endtask
  task t_act;
    gap(8);
    req(4'h3, 3'h5, 14'h0123, 1'b1);
    chk({cs_n, ras_n, cas_n, we_n, 1'b0, ba, st}, 11'h1A9);
    req(4'h3, 3'h5, 14'h0000, 1'b0);
    gap(4);
    req(4'h8, 3'h0, 14'h0000, 1'b1);
    wait_st(3'h2);
    gap(2);
    req(4'h9, 3'h0, 14'h0000, 1'b1);
    chk(st, 3'h1);
  endtask
  task t_burst;
    gap(8);
    req(4'h3, 3'h3, 14'h0000, 1'b1);
    req(4'h4, 3'h5, 14'h1400, 1'b1);
    chk({cs_n, ras_n, cas_n, we_n, 1'b0, addr}, 19'h21400);
    req(4'h5, 3'h3, 14'h0400, 1'b0);
    gap(2);
    req(4'h5, 3'h3, 14'h0400, 1'b1);
    chk({cs_n, ras_n, cas_n, we_n, 1'b0, ba}, 8'h53);
    gap(12);
    #1;
    chk(idle, 1'b1);
    @(posedge CLK_I);
    REQ_TERM_I <= 1'b0;
    @(posedge CLK_I) #1;
    chk({term, idle}, 2'h1);
    @(posedge CLK_I);
    REQ_TERM_I <= 1'b1;
    @(posedge CLK_I) #1;
    chk({term, idle}, 2'h3);
  endtask
  task t_sleep;
    req(4'hA, 3'h0, 14'h0000, 1'b1);
    chk({cke, cs_n, ras_n, cas_n, we_n}, 5'h01);
    gap(3);
    #1;
    chk({st, term}, 4'h8);
    req(4'hB, 3'h0, 14'h0000, 1'b1);
    chk({cke, cs_n, term}, 3'h6);
    req(4'h3, 3'h1, 14'h0000, 1'b0);
    gap(100);
    req(4'h3, 3'h1, 14'h0000, 1'b1);
    req(4'h5, 3'h1, 14'h0000, 1'b0);
    req(4'h4, 3'h1, 14'h0000, 1'b0);
    gap(410);
    req(4'h5, 3'h1, 14'h0000, 1'b1);
    cmd(3'h5);
    chk(term, 1'b1);
    gap(8);
    req(4'h2, 3'h0, 14'h0400, 1'b1);
    cmd(3'h2);
    gap(4);
    chk(dev_err[15:0], 16'h0000);
  endtask
  task print_verdict;
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      print_verdict;
    end
  end
  initial begin
    RST_N_I = 1'b0;
    REQ_VALID_I = 1'b0;
    REQ_OP_I = 4'h0;
    REQ_BANK_I = 3'h0;
    REQ_ADDR_I = 14'h0000;
    REQ_TERM_I = 1'b1;
    repeat (8) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_I) #1;
    chk({rst_n, cke, cs_n, ack}, 4'hE);
    t_codes;
    t_pd;
    t_act;
    t_burst;
    t_sleep;
    print_verdict;
  end
endmodule // sdcps_ctrl_test
